// *** tb_top.sv ***
// Testbench for the two-wire serial target
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic read_mode_in = 1'b0;
  logic [7:0] tx_data_in = 8'h00;
  logic scl, sda, sda_oe, sda_o, standby, busy, ack, rx_valid, tx_load;
  int n_rx = 0;
  int n_tx = 0;
  logic [7:0] rx_data, q;
  logic [31:0] seed = 32'hba193d31;
  int errors = 0;
  int checks_done = 0;
  int tries;
  initial forever #5 clk_in = !clk_in;
  tws_host tws_host_i (.clk_in, .dev_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
  tws_target #(.WR_CYCLES(150)) tws_target_i (.clk_in, .resetn_in, .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .read_mode_in, .tx_data_in, .tx_load_out(tx_load),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .standby_out(standby), .busy_out(busy));
  // One-cycle pulses are counted mid-cycle, where they stand settled
  always @(negedge clk_in)
  begin
    if (rx_valid === 1'b1)
      n_rx++;
    if (tx_load === 1'b1)
      n_tx++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic complete_run();
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (2) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk("standby", 8'h01, 8'(standby));
    for (int n = 0; n < 3; n++)
    begin
      seed = lfsr(seed);
      tws_host_i.cond(1'b0, 1'b1);
      tws_host_i.xfer(seed[7:0], 1'b1, q, ack);
      chk("ack", 8'h00, 8'(ack));
      chk("rx", seed[7:0], rx_data);
      tws_host_i.cond(1'b1, 1'b0);
      chk("busy", 8'h01, 8'(busy));
      tries = 0;
      ack = 1'b1;
      // Only the second poll lands after the write cycle
      while (ack !== 1'b0 && tries < 9)
      begin
        tries++;
        tws_host_i.cond(1'b0, 1'b1);
        tws_host_i.xfer(seed[15:8], 1'b1, q, ack);
        tws_host_i.cond(1'b1, 1'b0);
      end
      chk("polls", 8'h02, 8'(tries));
      repeat (160) @(negedge clk_in);
      read_mode_in = 1'b1;
      tx_data_in = seed[23:16];
      tws_host_i.cond(1'b0, 1'b1);
      tws_host_i.xfer(seed[31:24], 1'b1, q, ack);
      // Second byte is loaded only at the host acknowledge of the first
      tx_data_in = ~seed[23:16];
      tws_host_i.xfer(8'hff, 1'b0, q, ack);
      chk("tx", seed[23:16], q);
      tws_host_i.xfer(8'hff, 1'b1, q, ack);
      chk("tx next", ~seed[23:16], q);
      tws_host_i.cond(1'b1, 1'b0);
      read_mode_in = 1'b0;
      chk("standby", 8'h01, 8'(standby));
      chk("busy", 8'h00, 8'(busy));
      tws_host_i.xfer(seed[7:0], 1'b1, q, ack);
      chk("noack", 8'h01, 8'(ack));
    end
    // Per pass: write byte, two polls and the read command are received; two bytes sent
    chk("rx count", 8'h0c, 8'(n_rx));
    chk("load count", 8'h06, 8'(n_tx));
    chk("sda out", 8'h00, 8'(sda_o));
    complete_run();
  end
  initial
  begin
    repeat (10000) @(posedge clk_in);
    errors++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire

// *** tws_cond_det.sv ***
// Line edge and bus condition detector for the two-wire serial port
`timescale 1ns/100ps
`default_nettype none
module tws_cond_det (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_rise_out,
  output logic scl_fall_out,
  output logic start_out,
  output logic stop_out
);
  logic scl_q;
  logic scl_d;
  logic sda_q;
  logic sda_d;

  always_comb
  begin
    scl_d = scl_in;
    sda_d = sda_in;
  end

  // Idle bus level is high on both lines
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  assign scl_rise_out = scl_in & ~scl_q;
  assign scl_fall_out = ~scl_in & scl_q;
  // Data moving while clock stays high is a condition, never a bit
  assign start_out = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_out = scl_in & scl_q & ~sda_q & sda_in;
endmodule : tws_cond_det
`default_nettype wire

// *** tws_host.sv ***
// Host bus master model for the serial clock and data wire
`timescale 1ns/100ps
`default_nettype none
module tws_host (
  input wire logic clk_in,
  input wire logic dev_oe_in,
  output var logic scl_out,
  output logic sda_out
);
  logic pull = 1'b0;
  initial scl_out = 1'b1;
  // Pull-up wins unless someone pulls low
  assign sda_out = !(pull || dev_oe_in);
  task automatic half();
    repeat (3) @(negedge clk_in);
  endtask : half
  // Start is cond(0,1), stop is cond(1,0)
  task automatic cond(input logic first, input logic last);
    pull = first;
    half();
    scl_out = 1'b1;
    half();
    pull = last;
    half();
    scl_out = 1'b0;
    half();
  endtask : cond
  task automatic bit_x(input logic b, output logic s);
    pull = !b;
    half();
    scl_out = 1'b1;
    half();
    s = sda_out;
    scl_out = 1'b0;
    half();
  endtask : bit_x
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ack_in, ack);
  endtask : xfer
endmodule : tws_host
`default_nettype wire

// *** tws_pkg.sv ***
// Package of constants and state types for the two-wire serial target framing
package tws_pkg;
  localparam int unsigned WORD_BITS = 8;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WR_TIME_MS = 5;
  localparam int unsigned NS_PER_MS = 1000000;
  // Longest time: rounds down to whole cycles
  localparam int unsigned WR_CYCLES = (WR_TIME_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam logic RST_SDA_OE = 1'b0;
  localparam logic RST_STANDBY = 1'b1;

  typedef enum logic [2:0] {
    TWS_IDLE,
    TWS_RX,
    TWS_RX_ACK,
    TWS_TX,
    TWS_TX_ACK
  } tws_state_e;
endpackage : tws_pkg

// *** tws_target.sv ***
// Two-wire serial target: bit and word framing, acknowledge, standby and write cycle timer
`timescale 1ns/100ps
`default_nettype none
module tws_target #(
  parameter int unsigned WORD_W = tws_pkg::WORD_BITS,
  parameter int unsigned WR_CYCLES = tws_pkg::WR_CYCLES
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic read_mode_in,
  input wire logic [WORD_W-1:0] tx_data_in,
  output logic tx_load_out,
  output logic [WORD_W-1:0] rx_data_out,
  output logic rx_valid_out,
  output logic standby_out,
  output logic busy_out
);
  localparam int unsigned CNT_W = $clog2(WR_CYCLES + 1);
  localparam int unsigned BIT_W = $clog2(WORD_W + 1);
  localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(WORD_W - 1);
  localparam logic [BIT_W-1:0] FULL_WORD = BIT_W'(WORD_W);
  localparam logic [CNT_W-1:0] WR_LOAD = CNT_W'(WR_CYCLES);

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  tws_pkg::tws_state_e st_q;
  tws_pkg::tws_state_e st_d;
  logic [BIT_W-1:0] bit_q;
  logic [BIT_W-1:0] bit_d;
  logic [WORD_W-1:0] shreg_q;
  logic [WORD_W-1:0] shreg_d;
  logic oe_q;
  logic oe_d;
  logic host_ack_q;
  logic host_ack_d;
  logic read_seq_q;
  logic read_seq_d;
  logic write_seq_q;
  logic write_seq_d;
  logic standby_q;
  logic standby_d;
  logic [CNT_W-1:0] wr_cnt_q;
  logic [CNT_W-1:0] wr_cnt_d;
  logic [WORD_W-1:0] rx_data_q;
  logic [WORD_W-1:0] rx_data_d;
  logic rx_valid_q;
  logic rx_valid_d;
  logic tx_load_q;
  logic tx_load_d;
  logic busy;

  tws_cond_det u_cond (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall),
    .start_out(start_det),
    .stop_out(stop_det)
  );

  assign busy = (wr_cnt_q != '0);

  always_comb
  begin
    st_d = st_q;
    bit_d = bit_q;
    shreg_d = shreg_q;
    oe_d = oe_q;
    host_ack_d = host_ack_q;
    read_seq_d = read_seq_q;
    write_seq_d = write_seq_q;
    standby_d = standby_q;
    rx_data_d = rx_data_q;
    rx_valid_d = 1'b0;
    tx_load_d = 1'b0;
    // Internal write cycle runs out by itself, whatever the bus does
    wr_cnt_d = busy ? wr_cnt_q - CNT_W'(1) : wr_cnt_q;
    if (start_det)
    begin
      // A start always resynchronises framing, even mid-word
      st_d = tws_pkg::TWS_RX;
      bit_d = '0;
      oe_d = 1'b0;
      read_seq_d = 1'b0;
      write_seq_d = 1'b0;
      standby_d = 1'b0;
    end
    else if (stop_det)
    begin
      st_d = tws_pkg::TWS_IDLE;
      oe_d = 1'b0;
      if (read_seq_q)
        standby_d = 1'b1;
      else if (write_seq_q && !busy)
        wr_cnt_d = WR_LOAD;
      read_seq_d = 1'b0;
      write_seq_d = 1'b0;
    end
    else
    begin
      case (st_q)
        tws_pkg::TWS_IDLE:
        begin
          // Bits outside a started frame are ignored
          bit_d = bit_q;
        end
        tws_pkg::TWS_RX:
        begin
          if (scl_rise && bit_q != FULL_WORD)
          begin
            shreg_d = {shreg_q[WORD_W-2:0], sda_in};
            bit_d = bit_q + BIT_W'(1);
            if (bit_q == LAST_BIT)
            begin
              rx_data_d = {shreg_q[WORD_W-2:0], sda_in};
              rx_valid_d = 1'b1;
            end
          end
          else if (scl_fall && bit_q == FULL_WORD)
          begin
            st_d = tws_pkg::TWS_RX_ACK;
            // Withholding the acknowledge tells a polling host to retry
            oe_d = ~busy;
            write_seq_d = write_seq_q | ~busy;
          end
        end
        tws_pkg::TWS_RX_ACK:
        begin
          if (scl_fall)
          begin
            bit_d = '0;
            oe_d = 1'b0;
            if (!oe_q)
              st_d = tws_pkg::TWS_IDLE;
            else if (read_mode_in)
            begin
              st_d = tws_pkg::TWS_TX;
              shreg_d = tx_data_in;
              tx_load_d = 1'b1;
              oe_d = ~tx_data_in[WORD_W-1];
              read_seq_d = 1'b1;
            end
            else
              st_d = tws_pkg::TWS_RX;
          end
        end
        tws_pkg::TWS_TX:
        begin
          if (scl_rise)
            bit_d = bit_q + BIT_W'(1);
          else if (scl_fall)
          begin
            // Only the falling clock edge moves the output bit
            if (bit_q == FULL_WORD)
            begin
              st_d = tws_pkg::TWS_TX_ACK;
              oe_d = 1'b0;
            end
            else
            begin
              shreg_d = {shreg_q[WORD_W-2:0], 1'b0};
              oe_d = ~shreg_q[WORD_W-2];
            end
          end
        end
        tws_pkg::TWS_TX_ACK:
        begin
          if (scl_rise)
            host_ack_d = ~sda_in;
          else if (scl_fall)
          begin
            bit_d = '0;
            if (host_ack_q)
            begin
              st_d = tws_pkg::TWS_TX;
              shreg_d = tx_data_in;
              tx_load_d = 1'b1;
              oe_d = ~tx_data_in[WORD_W-1];
            end
            else
              st_d = tws_pkg::TWS_IDLE;
          end
        end
        default:
        begin
          st_d = tws_pkg::TWS_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_q <= tws_pkg::TWS_IDLE;
      bit_q <= '0;
      shreg_q <= '0;
      oe_q <= tws_pkg::RST_SDA_OE;
      host_ack_q <= 1'b0;
      read_seq_q <= 1'b0;
      write_seq_q <= 1'b0;
      standby_q <= tws_pkg::RST_STANDBY;
      wr_cnt_q <= '0;
      rx_data_q <= '0;
      rx_valid_q <= 1'b0;
      tx_load_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      bit_q <= bit_d;
      shreg_q <= shreg_d;
      oe_q <= oe_d;
      host_ack_q <= host_ack_d;
      read_seq_q <= read_seq_d;
      write_seq_q <= write_seq_d;
      standby_q <= standby_d;
      wr_cnt_q <= wr_cnt_d;
      rx_data_q <= rx_data_d;
      rx_valid_q <= rx_valid_d;
      tx_load_q <= tx_load_d;
    end
  end

  // Open drain: the pad only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_out = oe_q;
  assign tx_load_out = tx_load_q;
  assign rx_data_out = rx_data_q;
  assign rx_valid_out = rx_valid_q;
  assign standby_out = standby_q;
  assign busy_out = busy;
endmodule : tws_target
`default_nettype wire

// *** tws_target_asserts.sv ***
// Assertion checker for the two-wire serial target
`timescale 1ns/100ps
`default_nettype none
module tws_target_asserts #(
  parameter int unsigned WORD_W = tws_pkg::WORD_BITS,
  parameter int unsigned WR_CYCLES = tws_pkg::WR_CYCLES
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic read_mode_in,
  input wire logic [WORD_W-1:0] tx_data_in,
  input wire logic tx_load_out,
  input wire logic [WORD_W-1:0] rx_data_out,
  input wire logic rx_valid_out,
  input wire logic standby_out,
  input wire logic busy_out
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  always_comb cnt_d = busy_out ? cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge clk_in or negedge resetn_in)
    if (!resetn_in) cnt_q <= 32'h0;
    else cnt_q <= cnt_d;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_drive_low: assert property (sda_out == 1'b0) else $error("sda high");
  a_oe_rise_low: assert property ($rose(sda_oe_out) |-> !$past(scl_in)) else $error("oe on high");
  a_start_wake: assert property ($past(scl_in) && scl_in && $fell(sda_in) |-> ##[1:2] !standby_out)
    else $error("start");
  a_rx_pulse: assert property (rx_valid_out |=> !rx_valid_out) else $error("rx pulse");
  a_busy_mute: assert property (busy_out |-> !$rose(sda_oe_out)) else $error("busy ack");
  a_wr_time: assert property ($fell(busy_out) |-> cnt_q == WR_CYCLES) else $error("wr time");
  a_ack_follow: assert property (rx_valid_out && !busy_out |-> ##[1:20] sda_oe_out) else $error("ack");
  a_load_low: assert property (tx_load_out |-> !$past(scl_in)) else $error("load");
  c_rx: cover property (rx_valid_out);
  c_busy: cover property ($fell(busy_out));
  c_load: cover property (tx_load_out);
  c_standby: cover property ($rose(standby_out));
endmodule : tws_target_asserts
bind tws_target tws_target_asserts #(.WORD_W(WORD_W), .WR_CYCLES(WR_CYCLES)) tws_target_asserts_i (.clk_in,
  .resetn_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .read_mode_in, .tx_data_in, .tx_load_out,
  .rx_data_out, .rx_valid_out, .standby_out, .busy_out);
`default_nettype wire
